/* rtl/safe_stop_pkg.sv */
// constants, field layouts and carrier types for the safe-stop and door interlock sequencer
// assumes one 25 MHz clock and a synchronous active-high reset shared by all modules
`default_nettype none

package safe_stop_pkg;
    localparam int NUM_DRIVES = 4;
    localparam int SPEED_W = 16;
    localparam int SET_W = 16;
    localparam int MODE_W = 8;

    localparam int CLK_PERIOD_NS = 40;
    localparam int TICK_PERIOD_NS = 1000000;
    localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int XC_TOL_NS = 10000;
    localparam int XC_TOL_CYCLES = XC_TOL_NS / CLK_PERIOD_NS;

    localparam logic [MODE_W-1:0] MODE_SAFETY_COMMISSION = 8'h5F;

    localparam logic [1:0] SEL_DELAY_CU = 2'h0;
    localparam logic [1:0] SEL_DELAY_MM = 2'h1;
    localparam logic [1:0] SEL_RAMP = 2'h2;
    localparam logic [1:0] SEL_THRESH = 2'h3;

    localparam logic [SET_W-1:0] DELAY_RST = 16'h0064;
    localparam logic [SET_W-1:0] RAMP_RST = 16'h0064;
    localparam logic [SET_W-1:0] THRESH_RST = 16'h0010;
    localparam logic [SET_W-1:0] PASSWORD_RST = 16'h0000;

    typedef struct packed {
        logic [SET_W-1:0] delay_cu;
        logic [SET_W-1:0] delay_mm;
        logic [SET_W-1:0] ramp;
        logic [SET_W-1:0] thresh;
    } settings_type;

    typedef struct packed {
        logic wr;
        logic [1:0] sel;
        logic [SET_W-1:0] data;
    } cfg_write_type;

    typedef enum logic [2:0] {
        ST_SAFE = 3'h1,
        ST_IDLE = 3'h2,
        ST_RUN = 3'h4
    } seq_state_type;
endpackage

`default_nettype wire

/* rtl/dual_channel_check.sv */
// two-channel contact monitor with cross-circuit detection
// assumes both channels are equivalent contacts sampled on the system clock
`default_nettype none

module dual_channel_check
    import safe_stop_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ch_a,
    input wire logic ch_b,
    output logic closed,
    output logic fault
);
    logic [8:0] mis_q, mis_d;
    logic fault_q, fault_d;
    logic closed_q, closed_d;

    localparam logic [8:0] TOL = 9'(XC_TOL_CYCLES);

    always_comb begin
        mis_d = (ch_a != ch_b) ? ((mis_q == TOL) ? mis_q : mis_q + 9'h001) : 9'h000;
        // latched until both contacts open, so a welded channel cannot restart
        fault_d = (fault_q & (ch_a | ch_b)) | (mis_q == TOL);
        closed_d = ch_a & ch_b & ~fault_d;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mis_q <= 9'h000;
            fault_q <= 1'b0;
            closed_q <= 1'b0;
        end else begin
            mis_q <= mis_d;
            fault_q <= fault_d;
            closed_q <= closed_d;
        end
    end

    assign closed = closed_q;
    assign fault = fault_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_xc_fault;
        (ch_a != ch_b) [*8] ##0 (mis_q == TOL) |=> fault_q;
    endproperty
    a_xc_fault: assert property (p_xc_fault) else $error("cross fault missed");
endmodule // dual_channel_check

`default_nettype wire

/* rtl/stop_delay_timer.sv */
// per-drive safe-stop delay timer for the two redundant channels
// assumes tick is a one-cycle pulse per delay unit from the sequencer
`default_nettype none

module stop_delay_timer
    import safe_stop_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic tick,
    input wire logic stop_req,
    input wire logic [SET_W-1:0] delay_cu,
    input wire logic [SET_W-1:0] delay_mm,
    output logic torque_off_cu,
    output logic torque_off_mm
);
    logic [SET_W-1:0] elapsed_q, elapsed_d;
    logic off_cu_q, off_cu_d;
    logic off_mm_q, off_mm_d;

    always_comb begin
        elapsed_d = elapsed_q;
        if (!stop_req)
            elapsed_d = '0;
        else if (tick && elapsed_q != '1)
            elapsed_d = elapsed_q + 16'h0001;
        // torque stays on until the full delay, so the drive can ramp down first
        off_cu_d = stop_req & (elapsed_q >= delay_cu);
        off_mm_d = stop_req & (elapsed_q >= delay_mm);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            elapsed_q <= '1;
            off_cu_q <= 1'b1;
            off_mm_q <= 1'b1;
        end else begin
            elapsed_q <= elapsed_d;
            off_cu_q <= off_cu_d;
            off_mm_q <= off_mm_d;
        end
    end

    assign torque_off_cu = off_cu_q;
    assign torque_off_mm = off_mm_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_sto_delay;
        $rose(off_cu_q) |-> $past(stop_req) && $past(elapsed_q) >= $past(delay_cu);
    endproperty
    a_sto_delay: assert property (p_sto_delay) else $error("torque off too early");
endmodule // stop_delay_timer

`default_nettype wire

/* rtl/safe_stop_seq.sv */
// safe-stop and protective-door interlock sequencer for a group of drives
// assumes contact inputs are already debounced and synchronous to CLK
`default_nettype none

module safe_stop_seq
    import safe_stop_pkg::*;
#(
    parameter int TICK_CYCLES_P = TICK_CYCLES
) (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic ESTOP_CH_A,
    input wire logic ESTOP_CH_B,
    input wire logic DOOR_CH_A,
    input wire logic DOOR_CH_B,
    input wire logic ON_BUTTON,
    input wire logic ON_CIRCUIT_CONTACTS,
    input wire logic DRIVE_ENABLE,
    input wire logic RUN_COMMAND_OUT,
    input wire logic INFEED_ON,
    input wire logic LOCK_POSITION_MONITOR,
    input wire logic DOOR_LOCK_SOLENOID,
    input wire logic [NUM_DRIVES-1:0] DRIVE_TORQUE_OFF_ACTIVE,
    input wire logic [NUM_DRIVES-1:0][SPEED_W-1:0] DRIVE_SPEED,
    input wire cfg_write_type CFG_WRITE,
    input wire logic [MODE_W-1:0] COMMISSIONING_MODE_SELECT,
    input wire logic PASSWORD_WR,
    input wire logic [SET_W-1:0] PASSWORD_DATA,
    output logic [NUM_DRIVES-1:0] SAFE_STOP_REQ_A,
    output logic [NUM_DRIVES-1:0] SAFE_STOP_REQ_B,
    output logic [NUM_DRIVES-1:0] TORQUE_OFF_CU,
    output logic [NUM_DRIVES-1:0] TORQUE_OFF_MM,
    output logic GROUP_TORQUE_OFF_ACTIVE,
    output logic [NUM_DRIVES-1:0] BELOW_THRESHOLD,
    output logic [SET_W-1:0] STOP_DECEL_RAMP,
    output logic EMERGENCY_RELAY_READY,
    output logic DOOR_RELAY_READY,
    output logic ON_SHORT_FAULT,
    output logic CROSS_FAULT,
    output logic LOCK_VIOLATION,
    output logic INFEED_ACTIVE,
    output logic RUN_ACTIVE,
    output logic CFG_REFUSED,
    output logic [SET_W-1:0] PASSWORD_VALUE
);
    logic estop_closed, estop_fault, door_closed, door_fault;
    logic [NUM_DRIVES-1:0] off_cu, off_mm;
    logic [NUM_DRIVES-1:0] below;
    logic lock_violation, stop_req, all_below;

    // unit tick for the delay timers
    logic [15:0] tick_cnt_q, tick_cnt_d;
    logic tick;

    always_comb begin
        tick = (tick_cnt_q == 16'(TICK_CYCLES_P - 1));
        tick_cnt_d = tick ? 16'h0000 : tick_cnt_q + 16'h0001;
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST)
            tick_cnt_q <= 16'h0000;
        else
            tick_cnt_q <= tick_cnt_d;
    end

    dual_channel_check u_estop_check (
        .clk(CLK),
        .rst(SYS_RST),
        .ch_a(ESTOP_CH_A),
        .ch_b(ESTOP_CH_B),
        .closed(estop_closed),
        .fault(estop_fault)
    );

    dual_channel_check u_door_check (
        .clk(CLK),
        .rst(SYS_RST),
        .ch_a(DOOR_CH_A),
        .ch_b(DOOR_CH_B),
        .closed(door_closed),
        .fault(door_fault)
    );

    // settings and password
    settings_type set_q, set_d;
    logic [SET_W-1:0] pwd_q, pwd_d;
    logic refused_q, refused_d;
    logic cfg_ok;

    always_comb begin
        set_d = set_q;
        pwd_d = PASSWORD_WR ? PASSWORD_DATA : pwd_q;
        cfg_ok = (COMMISSIONING_MODE_SELECT == MODE_SAFETY_COMMISSION);
        refused_d = CFG_WRITE.wr & ~cfg_ok;
        if (CFG_WRITE.wr && cfg_ok) begin
            unique case (CFG_WRITE.sel)
                SEL_DELAY_CU: set_d.delay_cu = CFG_WRITE.data;
                SEL_DELAY_MM: set_d.delay_mm = CFG_WRITE.data;
                SEL_RAMP: set_d.ramp = CFG_WRITE.data;
                SEL_THRESH: set_d.thresh = CFG_WRITE.data;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            set_q <= '{delay_cu: DELAY_RST, delay_mm: DELAY_RST, ramp: RAMP_RST,
                       thresh: THRESH_RST};
            pwd_q <= PASSWORD_RST;
            refused_q <= 1'b0;
        end else begin
            set_q <= set_d;
            pwd_q <= pwd_d;
            refused_q <= refused_d;
        end
    end

    // emergency relay arming and on-circuit short check
    logic relay_ready_q, relay_ready_d;
    logic short_q, short_d;
    logic estop_released_q, estop_released_d;

    always_comb begin
        // release must be seen before ON, not in the same sample
        estop_released_d = estop_closed & ~estop_fault;
        // contacts closed while the emergency circuit is still open is a short
        short_d = (short_q | (ON_CIRCUIT_CONTACTS & ~estop_closed)) &
                  ~(~ON_CIRCUIT_CONTACTS & estop_closed);
        relay_ready_d = relay_ready_q;
        if (!estop_closed || estop_fault)
            relay_ready_d = 1'b0;
        else if (ON_BUTTON && estop_released_q && !short_q && !short_d)
            relay_ready_d = 1'b1;
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            relay_ready_q <= 1'b0;
            short_q <= 1'b0;
            estop_released_q <= 1'b0;
        end else begin
            relay_ready_q <= relay_ready_d;
            short_q <= short_d;
            estop_released_q <= estop_released_d;
        end
    end

    // hard-wired stop path: no controller state is needed to stop
    logic door_ready;
    logic group_off_q, below_all_q;
    logic [NUM_DRIVES-1:0] stop_q, below_q;
    logic lock_viol_q;

    always_comb begin
        // door relay only readies once the solenoid has dropped and the door is shut
        door_ready = door_closed & ~DOOR_LOCK_SOLENOID & relay_ready_q;
        // unlocking is only allowed once stopped and at standstill
        lock_violation = LOCK_POSITION_MONITOR & ~(group_off_q & below_all_q);
        // open contacts stop at once, not a cycle later through the relay register
        stop_req = ~relay_ready_q | ~estop_closed | ~door_ready | ~DRIVE_ENABLE
                   | lock_violation | door_fault | estop_fault;
        all_below = &below;
    end

    genvar g;
    generate
        for (g = 0; g < NUM_DRIVES; g++) begin : g_drive
            stop_delay_timer u_timer (
                .clk(CLK),
                .rst(SYS_RST),
                .tick(tick),
                .stop_req(stop_q[g]),
                .delay_cu(set_q.delay_cu),
                .delay_mm(set_q.delay_mm),
                .torque_off_cu(off_cu[g]),
                .torque_off_mm(off_mm[g])
            );
            assign below[g] = (DRIVE_SPEED[g] < set_q.thresh);
        end
    endgenerate

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            stop_q <= '1;
            below_q <= '0;
            group_off_q <= 1'b0;
            below_all_q <= 1'b0;
            lock_viol_q <= 1'b0;
        end else begin
            stop_q <= {NUM_DRIVES{stop_req}};
            below_q <= below;
            group_off_q <= &DRIVE_TORQUE_OFF_ACTIVE;
            below_all_q <= all_below;
            lock_viol_q <= lock_violation;
        end
    end

    // infeed and run sequencing
    seq_state_type state_q, state_d;
    logic infeed_q, infeed_d, infeed_cmd_q, run_cmd_q;

    always_comb begin
        // a static high never switches the infeed on
        infeed_d = INFEED_ON & (infeed_q | ~infeed_cmd_q);
        state_d = state_q;
        unique case (state_q)
            ST_SAFE: if (!stop_req && !(|off_cu) && !(|off_mm)) state_d = ST_IDLE;
            ST_IDLE: begin
                if (stop_req)
                    state_d = ST_SAFE;
                else if (RUN_COMMAND_OUT && !run_cmd_q && infeed_q)
                    state_d = ST_RUN;
            end
            ST_RUN: if (stop_req || !infeed_q) state_d = ST_SAFE;
            default: state_d = ST_SAFE;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            state_q <= ST_SAFE;
            infeed_q <= 1'b0;
            // taken as high so a level held through reset is not an edge
            infeed_cmd_q <= 1'b1;
            run_cmd_q <= 1'b1;
        end else begin
            state_q <= state_d;
            infeed_q <= infeed_d;
            infeed_cmd_q <= INFEED_ON;
            run_cmd_q <= RUN_COMMAND_OUT;
        end
    end

    assign SAFE_STOP_REQ_A = stop_q;
    assign SAFE_STOP_REQ_B = stop_q;
    assign TORQUE_OFF_CU = off_cu;
    assign TORQUE_OFF_MM = off_mm;
    assign GROUP_TORQUE_OFF_ACTIVE = group_off_q;
    assign BELOW_THRESHOLD = below_q;
    assign STOP_DECEL_RAMP = set_q.ramp;
    assign EMERGENCY_RELAY_READY = relay_ready_q;
    assign DOOR_RELAY_READY = door_ready;
    assign ON_SHORT_FAULT = short_q;
    assign CROSS_FAULT = estop_fault | door_fault;
    assign LOCK_VIOLATION = lock_viol_q;
    assign INFEED_ACTIVE = infeed_q;
    assign RUN_ACTIVE = (state_q == ST_RUN);
    assign CFG_REFUSED = refused_q;
    assign PASSWORD_VALUE = pwd_q;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    property p_estop_stop;
        !estop_closed |=> (&SAFE_STOP_REQ_A) && (&SAFE_STOP_REQ_B);
    endproperty
    a_estop_stop: assert property (p_estop_stop) else $error("estop not stopping");

    property p_group_off;
        !$past(SYS_RST) |-> GROUP_TORQUE_OFF_ACTIVE == $past(&DRIVE_TORQUE_OFF_ACTIVE);
    endproperty
    a_group_off: assert property (p_group_off) else $error("group feedback wrong");

    property p_below;
        (DRIVE_SPEED[0] >= set_q.thresh) |=> !BELOW_THRESHOLD[0];
    endproperty
    a_below: assert property (p_below) else $error("below flag wrong");

    property p_lock_stop;
        lock_violation |=> (&SAFE_STOP_REQ_A) && LOCK_VIOLATION;
    endproperty
    a_lock_stop: assert property (p_lock_stop) else $error("lock breach ignored");

    property p_infeed_edge;
        $rose(INFEED_ACTIVE) |-> $past(INFEED_ON) && !$past(infeed_cmd_q);
    endproperty
    a_infeed_edge: assert property (p_infeed_edge) else $error("infeed on by level");

    sequence s_run_edge;
        !run_cmd_q && RUN_COMMAND_OUT;
    endsequence
    property p_run_edge;
        $rose(RUN_ACTIVE) |-> $past(state_q == ST_IDLE) && $past(RUN_COMMAND_OUT)
            && !$past(run_cmd_q);
    endproperty
    a_run_edge: assert property (p_run_edge) else $error("run without edge");

    property p_run_start;
        ((state_q == ST_IDLE) && !stop_req && infeed_q) ##0 s_run_edge |=> RUN_ACTIVE;
    endproperty
    a_run_start: assert property (p_run_start) else $error("run edge lost");

    property p_cfg_lock;
        CFG_WRITE.wr && !cfg_ok |=> $stable(set_q) && CFG_REFUSED;
    endproperty
    a_cfg_lock: assert property (p_cfg_lock) else $error("setting changed");

    property p_enable_drop;
        !DRIVE_ENABLE |=> (&SAFE_STOP_REQ_A) && (&SAFE_STOP_REQ_B);
    endproperty
    a_enable_drop: assert property (p_enable_drop) else $error("enable drop ignored");
endmodule // safe_stop_seq

`default_nettype wire

/* bench/plc_model.sv */
// supervising controller model: drive enable, door lock solenoid, plausibility watch
// assumes relay and group feedback come from the sequencer on the same clock
`default_nettype none

module plc_model #(
    parameter int PLAUS_LIMIT = 200
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic door_req,
    input wire logic relay_ready,
    input wire logic group_off,
    input wire logic [3:0] below,
    output logic drive_enable,
    output logic solenoid,
    output logic implausible
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            drive_enable <= 1'b0;
            solenoid <= 1'b0;
            cnt_q <= 0;
            implausible <= 1'b0;
        end else begin
            // dropped to ask for the door, raised once the relay is ready
            drive_enable <= !door_req && relay_ready;
            // unlock only when stopped and slow, relock as soon as the request ends
            solenoid <= door_req && group_off && (&below);
            // relay open while drives still report torque on
            cnt_q <= (!relay_ready && !group_off) ? cnt_q + 1 : 0;
            if (cnt_q > PLAUS_LIMIT) begin
                implausible <= 1'b1;
            end
        end
    end
endmodule // plc_model

`default_nettype wire

/* bench/tb_safe_stop_seq.sv */
// self-checking bench for the safe-stop and door interlock sequencer
// assumes safe_stop_pkg and the plc_model partner are compiled first
`default_nettype none

module tb_safe_stop_seq;
    timeunit 1ns;
    timeprecision 1ps;
    import safe_stop_pkg::*;
    localparam int TICK = 4;
    localparam int DLY = 3;
    logic CLK = 1'b0;
    logic SYS_RST, ESTOP_CH_A, ESTOP_CH_B, DOOR_CH_A, DOOR_CH_B, ON_BUTTON;
    logic ON_CIRCUIT_CONTACTS, DRIVE_ENABLE, RUN_COMMAND_OUT, INFEED_ON;
    logic LOCK_POSITION_MONITOR, DOOR_LOCK_SOLENOID, PASSWORD_WR, door_req, implausible;
    logic [3:0] DRIVE_TORQUE_OFF_ACTIVE, hold_mask;
    logic [NUM_DRIVES-1:0][SPEED_W-1:0] DRIVE_SPEED;
    cfg_write_type CFG_WRITE;
    logic [MODE_W-1:0] COMMISSIONING_MODE_SELECT;
    logic [SET_W-1:0] PASSWORD_DATA, STOP_DECEL_RAMP, PASSWORD_VALUE;
    logic [3:0] SAFE_STOP_REQ_A, SAFE_STOP_REQ_B, TORQUE_OFF_CU, TORQUE_OFF_MM, BELOW_THRESHOLD;
    logic GROUP_TORQUE_OFF_ACTIVE, EMERGENCY_RELAY_READY, DOOR_RELAY_READY, ON_SHORT_FAULT;
    logic CROSS_FAULT, LOCK_VIOLATION, INFEED_ACTIVE, RUN_ACTIVE, CFG_REFUSED, refused_seen;
    int n_tests = 0;
    int n_mismatch = 0;
    int n_wait;

    always #20 CLK = ~CLK;
    // drives echo their own torque-off outputs; the mask holds some back
    assign DRIVE_TORQUE_OFF_ACTIVE = TORQUE_OFF_CU & TORQUE_OFF_MM & ~hold_mask;

    safe_stop_seq #(.TICK_CYCLES_P(TICK)) safe_stop_seq_i (
        .CLK(CLK), .SYS_RST(SYS_RST), .ESTOP_CH_A(ESTOP_CH_A), .ESTOP_CH_B(ESTOP_CH_B),
        .DOOR_CH_A(DOOR_CH_A), .DOOR_CH_B(DOOR_CH_B), .ON_BUTTON(ON_BUTTON),
        .ON_CIRCUIT_CONTACTS(ON_CIRCUIT_CONTACTS), .DRIVE_ENABLE(DRIVE_ENABLE),
        .RUN_COMMAND_OUT(RUN_COMMAND_OUT), .INFEED_ON(INFEED_ON),
        .LOCK_POSITION_MONITOR(LOCK_POSITION_MONITOR), .DOOR_LOCK_SOLENOID(DOOR_LOCK_SOLENOID),
        .DRIVE_TORQUE_OFF_ACTIVE(DRIVE_TORQUE_OFF_ACTIVE), .DRIVE_SPEED(DRIVE_SPEED),
        .CFG_WRITE(CFG_WRITE), .COMMISSIONING_MODE_SELECT(COMMISSIONING_MODE_SELECT),
        .PASSWORD_WR(PASSWORD_WR), .PASSWORD_DATA(PASSWORD_DATA),
        .SAFE_STOP_REQ_A(SAFE_STOP_REQ_A), .SAFE_STOP_REQ_B(SAFE_STOP_REQ_B),
        .TORQUE_OFF_CU(TORQUE_OFF_CU), .TORQUE_OFF_MM(TORQUE_OFF_MM),
        .GROUP_TORQUE_OFF_ACTIVE(GROUP_TORQUE_OFF_ACTIVE), .BELOW_THRESHOLD(BELOW_THRESHOLD),
        .STOP_DECEL_RAMP(STOP_DECEL_RAMP), .EMERGENCY_RELAY_READY(EMERGENCY_RELAY_READY),
        .DOOR_RELAY_READY(DOOR_RELAY_READY), .ON_SHORT_FAULT(ON_SHORT_FAULT),
        .CROSS_FAULT(CROSS_FAULT), .LOCK_VIOLATION(LOCK_VIOLATION),
        .INFEED_ACTIVE(INFEED_ACTIVE), .RUN_ACTIVE(RUN_ACTIVE), .CFG_REFUSED(CFG_REFUSED),
        .PASSWORD_VALUE(PASSWORD_VALUE));

    plc_model plc_model_i (
        .clk(CLK), .rst(SYS_RST), .door_req(door_req), .relay_ready(EMERGENCY_RELAY_READY),
        .group_off(GROUP_TORQUE_OFF_ACTIVE), .below(BELOW_THRESHOLD),
        .drive_enable(DRIVE_ENABLE), .solenoid(DOOR_LOCK_SOLENOID), .implausible(implausible));

    task automatic step();
        @(posedge CLK);
        #2;
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    function automatic logic [3:0] probe(input int id);
        case (id)
            0: return SAFE_STOP_REQ_A;
            1: return TORQUE_OFF_CU;
            2: return {3'h0, GROUP_TORQUE_OFF_ACTIVE};
            3: return {3'h0, RUN_ACTIVE};
            4: return {3'h0, CROSS_FAULT};
            5: return {3'h0, DOOR_LOCK_SOLENOID};
            6: return {3'h0, INFEED_ACTIVE};
            default: return {3'h0, EMERGENCY_RELAY_READY};
        endcase
    endfunction

    // a wait that runs out ends the run at once
    task automatic wait_for(input int id, input logic [3:0] v, input int lim, input string nm);
        int k;
        k = 0;
        while (k < lim && probe(id) !== v) begin
            step();
            k++;
        end
        n_wait = k;
        chk(nm, {12'h000, probe(id)}, {12'h000, v});
        if (probe(id) !== v) final_report();
    endtask

    // write strobe is dropped for a cycle so back-to-back calls never re-drive it
    task automatic cfg(input logic [1:0] sel, input logic [15:0] d);
        CFG_WRITE = {1'b1, sel, d};
        step();
        refused_seen = CFG_REFUSED;
        CFG_WRITE.wr = 1'b0;
        step();
    endtask

    initial begin
        SYS_RST = 1'b1;
        {ESTOP_CH_A, ESTOP_CH_B, DOOR_CH_A, DOOR_CH_B, ON_BUTTON, ON_CIRCUIT_CONTACTS} = '0;
        {LOCK_POSITION_MONITOR, PASSWORD_WR, door_req} = '0;
        {RUN_COMMAND_OUT, INFEED_ON} = 2'h3;
        hold_mask = 4'h0;
        DRIVE_SPEED = {4{16'h0100}};
        CFG_WRITE = '0;
        COMMISSIONING_MODE_SELECT = 8'h00;
        PASSWORD_DATA = 16'h0000;
        repeat (12) step();
        SYS_RST = 1'b0;
        repeat (3) step();
        chk("stop_a", SAFE_STOP_REQ_A, 16'h000F);
        chk("torque_mm", TORQUE_OFF_MM, 16'h000F);
        chk("infeed", INFEED_ACTIVE, 16'h0000);
        $display("test reset done");

        cfg(SEL_DELAY_CU, 16'h0003);
        chk("refused", refused_seen, 16'h0001);
        PASSWORD_WR = 1'b1;
        PASSWORD_DATA = 16'h1234;
        step();
        PASSWORD_WR = 1'b0;
        step();
        chk("password", PASSWORD_VALUE, 16'h1234);
        COMMISSIONING_MODE_SELECT = MODE_SAFETY_COMMISSION;
        cfg(SEL_DELAY_CU, DLY[15:0]);
        chk("accepted", refused_seen, 16'h0000);
        cfg(SEL_DELAY_MM, DLY[15:0]);
        cfg(SEL_RAMP, 16'h0123);
        cfg(SEL_THRESH, 16'h0010);
        COMMISSIONING_MODE_SELECT = 8'h00;
        cfg(SEL_RAMP, 16'h0456);
        step();
        chk("ramp", STOP_DECEL_RAMP, 16'h0123);
        $display("test settings done");

        ON_CIRCUIT_CONTACTS = 1'b1;
        ON_BUTTON = 1'b1;
        repeat (2) step();
        ON_BUTTON = 1'b0;
        step();
        chk("short", ON_SHORT_FAULT, 16'h0001);
        chk("relay_refused", EMERGENCY_RELAY_READY, 16'h0000);
        {ESTOP_CH_A, ESTOP_CH_B, DOOR_CH_A, DOOR_CH_B} = 4'hF;
        step();
        ON_CIRCUIT_CONTACTS = 1'b0;
        repeat (3) step();
        chk("short_clear", ON_SHORT_FAULT, 16'h0000);
        ON_BUTTON = 1'b1;
        step();
        ON_BUTTON = 1'b0;
        wait_for(7, 4'h1, 4, "relay_ready");
        wait_for(0, 4'h0, 8, "stop_off");
        chk("stop_b_off", SAFE_STOP_REQ_B, 16'h0000);
        wait_for(1, 4'h0, 3, "torque_on");
        chk("infeed_static", INFEED_ACTIVE, 16'h0000);
        INFEED_ON = 1'b0;
        step();
        INFEED_ON = 1'b1;
        wait_for(6, 4'h1, 4, "infeed_edge");
        repeat (2) step();
        chk("run_static", RUN_ACTIVE, 16'h0000);
        RUN_COMMAND_OUT = 1'b0;
        step();
        RUN_COMMAND_OUT = 1'b1;
        wait_for(3, 4'h1, 4, "run_edge");
        DRIVE_SPEED = {16'h0000, 16'h0011, 16'h0010, 16'h000F};
        repeat (3) step();
        chk("below", BELOW_THRESHOLD, 16'h0009);
        $display("test start done");

        DRIVE_SPEED = '0;
        hold_mask = 4'h1;
        door_req = 1'b1;
        wait_for(0, 4'hF, 4, "door_stop");
        wait_for(1, 4'hF, 40, "delay_cu");
        chk("delay_full", n_wait >= (DLY - 1) * TICK, 16'h0001);
        wait_for(1, 4'hF, 3, "delay_cu");
        repeat (4) step();
        chk("torque_mm", TORQUE_OFF_MM, 16'h000F);
        chk("group_part", GROUP_TORQUE_OFF_ACTIVE, 16'h0000);
        chk("ramp_kept", STOP_DECEL_RAMP, 16'h0123);
        hold_mask = 4'h0;
        wait_for(2, 4'h1, 3, "group_all");
        wait_for(5, 4'h1, 3, "unlock");
        {DOOR_CH_A, DOOR_CH_B} = 2'h0;
        repeat (2) step();
        chk("door_relay", DOOR_RELAY_READY, 16'h0000);
        {DOOR_CH_A, DOOR_CH_B} = 2'h3;
        door_req = 1'b0;
        wait_for(5, 4'h0, 3, "relock");
        wait_for(0, 4'h0, 8, "restart");
        chk("door_ready", DOOR_RELAY_READY, 16'h0001);
        $display("test door done");

        DRIVE_SPEED = {4{16'h0100}};
        LOCK_POSITION_MONITOR = 1'b1;
        wait_for(0, 4'hF, 4, "lock_stop");
        chk("lock_viol", LOCK_VIOLATION, 16'h0001);
        LOCK_POSITION_MONITOR = 1'b0;
        wait_for(0, 4'h0, 8, "lock_clear");
        $display("test lock done");

        {ESTOP_CH_A, ESTOP_CH_B} = 2'h0;
        wait_for(0, 4'hF, 4, "estop");
        chk("estop_b", SAFE_STOP_REQ_B, 16'h000F);
        wait_for(1, 4'hF, 40, "estop_torque");
        wait_for(2, 4'h1, 6, "estop_group");
        chk("plausible", implausible, 16'h0000);
        $display("test emergency done");

        ESTOP_CH_A = 1'b1;
        wait_for(4, 4'h1, 270, "cross");
        chk("cross_tol", n_wait >= 200, 16'h0001);
        ESTOP_CH_A = 1'b0;
        wait_for(4, 4'h0, 5, "cross_clear");
        $display("test cross done");
        final_report();
    end
endmodule // tb_safe_stop_seq

`default_nettype wire
